// file: ref_clock_switch.sv
/*
 * Redundant reference clock switch: two differential reference inputs,
 * loss monitors, manual selection and automatic fail-over with return.
 * Assumes all pin inputs are asynchronous to REF_CLK and are sampled
 * here; the switch itself models the pull-up on the auto switch select line.
 */
// Function
// - Exactly one reference input feeds the PLL at any time.
// - Input 0 is the primary clock, input 1 the secondary.
// - Indicator low while input 0 is used, high for input 1.
// - Input stuck for a full feedback period is declared failed.
// - Each input has its own loss flag, raised on failure.
// - Loss flags follow live input status and clear when good again.
// - Auto select low means manual select always wins, even on failure.
// - Manual select change switches input and updates the indicator.
// - Undriven auto switch select reads high, enabling dynamic switching.
// - Primary failed and secondary good: switch to the secondary.
// - After fail-over the indicator shows the new reference.
// - Primary recovered: flag clears first, then switch back to primary.
`timescale 1ns/1ps
`include "refsw_cfg.svh"

module ref_clock_switch
    import refsw_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST,
    // Reference input 0 pair
    input wire logic REFERENCE_INPUT0_TRUE,
    input wire logic REFERENCE_INPUT0_COMPLEMENT,
    // Reference input 1 pair
    input wire logic REFERENCE_INPUT1_TRUE,
    input wire logic REFERENCE_INPUT1_COMPLEMENT,
    // PLL feedback clock
    input wire logic FEEDBACK_CLK,
    // Board control pins
    input wire logic AUTO_SWITCH_SELECT,
    input wire logic AUTO_SWITCH_DRIVEN,
    input wire logic MANUAL_REFERENCE_SELECT,
    // Status and reference outputs
    output logic REFERENCE_INDICATOR,
    output logic LOSS_FLAG_INPUT0,
    output logic LOSS_FLAG_INPUT1,
    output logic DYNAMIC_SWITCHING,
    output logic PLL_REFERENCE
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [`REFSW_SYNC_W-1:0] sync1_q;
    logic [`REFSW_SYNC_W-1:0] sync2_q;
    logic fb_prev_q;

    // Two flops on every pin before any logic reads it
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {FEEDBACK_CLK, AUTO_SWITCH_SELECT, AUTO_SWITCH_DRIVEN,
                        MANUAL_REFERENCE_SELECT, REFERENCE_INPUT1_COMPLEMENT,
                        REFERENCE_INPUT1_TRUE, REFERENCE_INPUT0_COMPLEMENT,
                        REFERENCE_INPUT0_TRUE};
            sync2_q <= sync1_q;
        end
    end

    // Delayed feedback level for edge detection
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            fb_prev_q <= 1'b0;
        end else begin
            fb_prev_q <= sync2_q[7];
        end
    end

    // ****************************************************************
    // Decoded inputs
    // ****************************************************************
    logic level0;
    logic level1;
    logic fb_edge;
    logic auto_eff;
    logic man_sel;

    // Differential decode: an equal pair reads low and looks stuck
    assign level0 = sync2_q[0] & ~sync2_q[1];
    assign level1 = sync2_q[2] & ~sync2_q[3];
    assign man_sel = sync2_q[4];
    assign auto_eff = sync2_q[5] ? sync2_q[6] : 1'b1;
    // Rising edge of feedback clock
    assign fb_edge = sync2_q[7] & ~fb_prev_q;

    // ****************************************************************
    // Loss monitors
    // ****************************************************************
    logic loss0;
    logic loss1;

    ref_loss_monitor #(
        .CNT_W(`REFSW_LOSS_CNT_W),
        .FB_PERIODS(`REFSW_LOSS_FB_PERIODS)
    ) u_mon0 (
        .clk(REF_CLK),
        .rst(RST),
        .level(level0),
        .fb_edge(fb_edge),
        .loss_q(loss0)
    );

    ref_loss_monitor #(
        .CNT_W(`REFSW_LOSS_CNT_W),
        .FB_PERIODS(`REFSW_LOSS_FB_PERIODS)
    ) u_mon1 (
        .clk(REF_CLK),
        .rst(RST),
        .level(level1),
        .fb_edge(fb_edge),
        .loss_q(loss1)
    );

    assign LOSS_FLAG_INPUT0 = loss0;
    assign LOSS_FLAG_INPUT1 = loss1;

    // ****************************************************************
    // Selection state machine
    // ****************************************************************
    ref_state_t state_q;
    ref_state_t state_d;

    // Next reference choice
    always_comb begin
        state_d = state_q;
        if (!auto_eff) begin
            // manual select wins; follow its level
            state_d = man_sel ? ST_SECONDARY : ST_PRIMARY;
        end else begin
            case (state_q)
                ST_PRIMARY: begin
                    // fail over only if secondary good; else hold
                    if (loss0 && !loss1) begin
                        state_d = ST_SECONDARY;
                    end
                end
                ST_SECONDARY: begin
                    // registered flag clears before the return
                    if (!loss0) begin
                        state_d = ST_PRIMARY;
                    end
                end
                default: begin
                    state_d = ST_PRIMARY;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state_q <= ST_PRIMARY;
        end else begin
            state_q <= state_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // indicator low for input 0; updated with the switch
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            REFERENCE_INDICATOR <= `REFSW_SEL_RESET;
        end else begin
            REFERENCE_INDICATOR <= (state_d == ST_SECONDARY);
        end
    end

    // single input muxed to the PLL
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            PLL_REFERENCE <= 1'b0;
        end else begin
            PLL_REFERENCE <= (state_q == ST_SECONDARY) ? level1 : level0;
        end
    end

    // Dynamic switching enable status
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            DYNAMIC_SWITCHING <= `REFSW_DYN_RESET;
        end else begin
            DYNAMIC_SWITCHING <= auto_eff;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    a_pll_single_source: assert property (
        PLL_REFERENCE == ($past(state_q == ST_SECONDARY) ? $past(level1) : $past(level0)))
        else $error("PLL reference not taken from the selected input alone");

    a_primary_after_reset: assert property (
        $fell(RST) |-> !REFERENCE_INDICATOR && state_q == ST_PRIMARY)
        else $error("primary not selected after reset");

    a_indicator_level: assert property (
        PLL_REFERENCE == ($past(REFERENCE_INDICATOR) ? $past(level1) : $past(level0)))
        else $error("indicator does not match the input feeding the PLL");

    a_manual_hold: assert property (
        !auto_eff |=> state_q == ($past(man_sel) ? ST_SECONDARY : ST_PRIMARY))
        else $error("manual selection not followed");

    a_manual_change: assert property (
        (!auto_eff && $changed(man_sel)) |=> REFERENCE_INDICATOR == $past(man_sel))
        else $error("manual change not shown on indicator");

    a_undriven_dynamic: assert property (
        !sync2_q[5] |=> DYNAMIC_SWITCHING)
        else $error("undriven select did not enable dynamic switching");

    a_fail_over: assert property (
        (auto_eff && state_q == ST_PRIMARY && loss0 && !loss1)
        |=> state_q == ST_SECONDARY && REFERENCE_INDICATOR)
        else $error("no fail-over to a good secondary");

    a_return_primary: assert property (
        (auto_eff && state_q == ST_SECONDARY && $fell(loss0)) |-> ##1 state_q == ST_PRIMARY)
        else $error("no return to primary after recovery");

    a_both_failed_hold: assert property (
        (auto_eff && state_q == ST_PRIMARY && loss1) |=> state_q == ST_PRIMARY)
        else $error("switched to a failed secondary");

    c_fail_over: cover property (
        auto_eff && state_q == ST_PRIMARY ##1 state_q == ST_SECONDARY);
    c_return: cover property (
        auto_eff && state_q == ST_SECONDARY ##1 state_q == ST_PRIMARY);
    c_manual_switch: cover property (
        !auto_eff && $rose(REFERENCE_INDICATOR));
    c_both_lost: cover property (
        loss0 && loss1);

endmodule

// file: refsw_cfg.svh
/*
 * Constants for the redundant reference clock switch: reset values,
 * synchroniser width and loss-detection timing.
 * Assumes inclusion by bare name from the design modules.
 */
`ifndef REFSW_CFG_SVH
`define REFSW_CFG_SVH

// ****************************************************************
// Reset values
// ****************************************************************
`define REFSW_SEL_RESET 1'b0
`define REFSW_LOSS_RESET 1'b0
`define REFSW_DYN_RESET 1'b1

// ****************************************************************
// Timing
// ****************************************************************
// Feedback periods without an input transition before loss is flagged
`define REFSW_LOSS_FB_PERIODS 1
// Width of the per-input feedback edge counter
`define REFSW_LOSS_CNT_W 2
// Number of pin inputs passing the synchroniser
`define REFSW_SYNC_W 8

`endif

// file: refsw_pkg.sv
/*
 * Types shared by the redundant reference clock switch.
 * Assumes refsw_cfg.svh is on the include path.
 */
package refsw_pkg;

    // ****************************************************************
    // Reference selection state
    // ****************************************************************
    typedef enum logic {
        ST_PRIMARY,
        ST_SECONDARY
    } ref_state_t;

endpackage

// file: ref_loss_monitor.sv
/*
 * Loss-of-reference monitor for one reference input.
 * Assumes a level already synchronised to clk and a one-cycle pulse
 * for each rising edge of the feedback clock, both from the same domain.
 */
`timescale 1ns/1ps
`include "refsw_cfg.svh"

module ref_loss_monitor
    import refsw_pkg::*;
#(
    parameter int CNT_W = `REFSW_LOSS_CNT_W,
    parameter int FB_PERIODS = `REFSW_LOSS_FB_PERIODS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Monitored input and feedback timing
    input wire logic level,
    input wire logic fb_edge,
    // Live loss flag
    output logic loss_q
);

    // ****************************************************************
    // Parameter check
    // ****************************************************************
    if (FB_PERIODS < 1 || FB_PERIODS + 1 >= (1 << CNT_W)) begin : g_bad_param
        $error("ref_loss_monitor: FB_PERIODS does not fit CNT_W");
    end

    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(FB_PERIODS + 1);

    logic level_q;
    logic [CNT_W-1:0] cnt_q;
    logic in_edge;

    // ****************************************************************
    // Edge detection and counting
    // ****************************************************************
    // Any transition of the input counts as activity
    assign in_edge = level ^ level_q;

    // Previous input level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_q <= 1'b0;
        end else begin
            level_q <= level;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (in_edge) begin
            cnt_q <= '0;
        end else if (fb_edge && cnt_q != LIMIT) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // raise own flag; clear on activity
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loss_q <= `REFSW_LOSS_RESET;
        end else if (in_edge) begin
            loss_q <= 1'b0;
        end else if (fb_edge && cnt_q == LIMIT - 1'b1) begin
            loss_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_loss_raise_cause: assert property (
        @(posedge clk) disable iff (rst)
        $rose(loss_q) |-> $past(fb_edge) && $past(cnt_q) == LIMIT - 1'b1 && !$past(in_edge))
        else $error("loss flag raised without a full stuck feedback period");

    a_loss_clear_live: assert property (
        @(posedge clk) disable iff (rst)
        in_edge |=> !loss_q && cnt_q == '0)
        else $error("loss flag not cleared after input activity");

    a_loss_stuck_sets: assert property (
        @(posedge clk) disable iff (rst)
        (!in_edge && fb_edge && cnt_q == LIMIT - 1'b1) |=> loss_q)
        else $error("stuck input not flagged");

endmodule

// file: ref_source_model.sv
/*
 * Board model: two reference clock sources and the PLL feedback clock.
 * Assumes clk is the 10 MHz system clock; all sources move on its falling edge.
 */
`timescale 1ns/1ps

module ref_source_model (
    // System clock
    input wire logic clk,
    // Source controls from the bench
    input wire logic run0,
    input wire logic run1,
    input wire logic stuck0,
    input wire logic stuck1,
    // Differential reference pairs
    output logic in0_t,
    output logic in0_c,
    output logic in1_t,
    output logic in1_c,
    // Free-running feedback clock
    output logic fb_clk
);
    // ****************************************************************
    // Clock generation
    // ****************************************************************
    logic [3:0] ref_cnt_q = 4'h0;
    logic [3:0] fb_cnt_q = 4'h0;
    logic ref_q = 1'b0;
    logic fb_q = 1'b0;

    // Half periods of 8 and 6 cycles: a live source toggles inside any feedback period
    always_ff @(negedge clk) begin
        ref_cnt_q <= (ref_cnt_q == 4'h7) ? 4'h0 : ref_cnt_q + 4'h1;
        fb_cnt_q <= (fb_cnt_q == 4'h5) ? 4'h0 : fb_cnt_q + 4'h1;
        if (ref_cnt_q == 4'h7) begin
            ref_q <= ~ref_q;
        end
        if (fb_cnt_q == 4'h5) begin
            fb_q <= ~fb_q;
        end
    end

    // A stopped source holds its stuck level on the pair
    assign in0_t = run0 ? ref_q : stuck0;
    assign in0_c = ~in0_t;
    assign in1_t = run1 ? ref_q : stuck1;
    assign in1_c = ~in1_t;
    assign fb_clk = fb_q;
endmodule

// file: testbench.sv
/*
 * Self-checking bench for the reference clock switch.
 * Assumes ref_source_model supplies the reference pairs and feedback clock.
 */
`timescale 1ns/1ps

module testbench;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    logic ref_clk, rst, run0, run1, stuck0, stuck1, auto_sel, auto_drv, man_sel;
    logic i0t, i0c, i1t, i1c, fb, ind, loss0, loss1, dyn, pll;
    int fails = 0;
    int total_checks = 0;
    int cycles = 0;
    int i;

    ref_source_model u_ref_source_model (.clk(ref_clk), .run0(run0), .run1(run1),
        .stuck0(stuck0), .stuck1(stuck1), .in0_t(i0t), .in0_c(i0c), .in1_t(i1t),
        .in1_c(i1c), .fb_clk(fb));

    ref_clock_switch u_ref_clock_switch (.REF_CLK(ref_clk), .RST(rst),
        .REFERENCE_INPUT0_TRUE(i0t), .REFERENCE_INPUT0_COMPLEMENT(i0c),
        .REFERENCE_INPUT1_TRUE(i1t), .REFERENCE_INPUT1_COMPLEMENT(i1c),
        .FEEDBACK_CLK(fb), .AUTO_SWITCH_SELECT(auto_sel), .AUTO_SWITCH_DRIVEN(auto_drv),
        .MANUAL_REFERENCE_SELECT(man_sel), .REFERENCE_INDICATOR(ind),
        .LOSS_FLAG_INPUT0(loss0), .LOSS_FLAG_INPUT1(loss1), .DYNAMIC_SWITCHING(dyn),
        .PLL_REFERENCE(pll));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic give_verdict;
        if (fails == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic exp, input logic got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    // Reset values with the auto select line left floating
    task automatic t_reset;
        check("indicator", 1'b0, ind);
        check("loss0", 1'b0, loss0);
        check("loss1", 1'b0, loss1);
        check("dynamic", 1'b1, dyn);
        check("pll_ref", 1'b0, pll);
    endtask

    // Primary sticks high, fail-over, then recovery and return
    task automatic t_failover;
        idle(40);
        check("dynamic", 1'b1, dyn);
        check("loss0", 1'b0, loss0);
        check("loss1", 1'b0, loss1);
        run0 = 1'b0;
        stuck0 = 1'b1;
        idle(10);
        check("loss0", 1'b0, loss0);
        idle(30);
        check("loss0", 1'b1, loss0);
        check("loss1", 1'b0, loss1);
        check("indicator", 1'b1, ind);
        run0 = 1'b1;
        for (i = 0; i < 40 && loss0 !== 1'b0; i++) idle(1);
        check("loss0", 1'b0, loss0);
        check("indicator", 1'b1, ind);
        idle(2);
        check("indicator", 1'b0, ind);
    endtask

    // Secondary fails first, then primary: no switch
    task automatic t_both_fail;
        run1 = 1'b0;
        idle(40);
        check("loss1", 1'b1, loss1);
        check("indicator", 1'b0, ind);
        run0 = 1'b0;
        stuck0 = 1'b0;
        idle(40);
        check("loss0", 1'b1, loss0);
        check("indicator", 1'b0, ind);
        run0 = 1'b1;
        run1 = 1'b1;
        idle(40);
    endtask

    // Manual mode: selection holds on failed inputs, follows the select pin
    task automatic t_manual;
        auto_drv = 1'b1;
        idle(4);
        check("dynamic", 1'b0, dyn);
        run0 = 1'b0;
        run1 = 1'b0;
        stuck1 = 1'b1;
        man_sel = 1'b1;
        idle(40);
        check("loss1", 1'b1, loss1);
        check("indicator", 1'b1, ind);
        check("pll_ref", 1'b1, pll);
        man_sel = 1'b0;
        idle(2);
        check("indicator", 1'b1, ind);
        idle(2);
        check("indicator", 1'b0, ind);
        idle(2);
        check("pll_ref", 1'b0, pll);
        auto_drv = 1'b0;
        idle(4);
        check("dynamic", 1'b1, dyn);
        auto_drv = 1'b1;
        auto_sel = 1'b1;
        idle(4);
        check("dynamic", 1'b1, dyn);
        run0 = 1'b1;
        run1 = 1'b1;
    endtask

    // ****************************************************************
    // Clock, timeout and main sequence
    // ****************************************************************
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // Cut a hang short well beyond the few hundred cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles >= 2000) begin
            fails++;
            give_verdict;
        end
    end

    initial begin
        rst = 1'b1;
        run0 = 1'b1;
        run1 = 1'b1;
        stuck0 = 1'b0;
        stuck1 = 1'b0;
        auto_sel = 1'b0;
        auto_drv = 1'b0;
        man_sel = 1'b0;
        idle(5);
        t_reset;
        rst = 1'b0;
        t_failover;
        t_both_fail;
        t_manual;
        give_verdict;
    end
endmodule
